/* tb_wdt_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_wdt_top;
  localparam int T = 8;
  logic                  clk;
  logic                  rstn;
  wdt_pkg::wdt_apb_req_t req;
  wdt_pkg::wdt_apb_rsp_t rsp;
  logic                  osc;
  logic                  sleep;
  logic                  ack;
  logic                  nmi;
  logic [2:0]            lvl;
  logic [23:0]           vec;
  logic                  irq;
  logic [7:0]            misc;
  logic [31:0]           rd;
  logic                  err;
  int                    seen;
  int                    bad_count;
  int                    total_checks;
  wdt_top #(.TIMEOUT_TICKS(17'(T))) DUT (.clk(clk), .rstn(rstn), .apb_req(req), .apb_rsp_q(rsp),
    .low_speed_oscillator(osc), .sleep_active(sleep), .nmi_ack(ack), .nmi_req_q(nmi), .nmi_level_q(lvl),
    .nmi_vector_q(vec), .irq_q(irq), .ctrl_misc_q(misc));
  wdt_cpu_model CPU (.clk(clk), .rstn(rstn), .nmi_req_q(nmi), .ack_delay(4'h5), .nmi_ack(ack), .nmi_seen(seen));
  always #2 clk = ~clk;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp
  // one apb transfer, released one cycle before the next
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    if (n == 20) bad_count++;
    @(posedge clk);
  endtask : apb
  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    cmp(rd, exp);
  endtask : rdchk
  task automatic tick(input int n);
    repeat (n) begin
      osc <= 1'b1;
      repeat (3) @(posedge clk);
      osc <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask : tick
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end
  initial begin
    clk = 0; rstn = 0; req = '0; osc = 0; sleep = 0; bad_count = 0; total_checks = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    cmp({29'h0, lvl}, 32'h4);
    cmp({8'h0, vec}, 32'h4);
    for (int i = 0; i < 4; i++) rdchk(wdt_pkg::WDT_CTRL_OFF + 16'(4 * i), 32'h0);
    tick(3);
    rdchk(wdt_pkg::WDT_COUNT_OFF, 32'h3);
    // sleep freezes the count at 3 across five ticks
    sleep <= 1'b1;
    tick(5);
    sleep <= 1'b0;
    rdchk(wdt_pkg::WDT_COUNT_OFF, 32'h3);
    apb(1'b1, wdt_pkg::WDT_CTRL_OFF, 32'h0);
    rdchk(wdt_pkg::WDT_COUNT_OFF, 32'h3);
    apb(1'b1, wdt_pkg::WDT_CTRL_OFF, 32'hff);
    rdchk(wdt_pkg::WDT_CTRL_OFF, 32'h7b);
    cmp({24'h0, misc}, 32'h7b);
    rdchk(wdt_pkg::WDT_COUNT_OFF, 32'h0);
    repeat (3) begin
      tick(T - 2);
      apb(1'b1, wdt_pkg::WDT_CTRL_OFF, 32'h4);
    end
    cmp(seen, 0);
    apb(1'b1, wdt_pkg::WDT_MASK_OFF, 32'h1);
    tick(T - 1);
    cmp(seen, 0);
    tick(1);
    repeat (12) @(posedge clk);
    cmp(seen, 1);
    cmp({31'h0, nmi}, 32'h0);
    cmp({31'h0, irq}, 32'h1);
    rdchk(wdt_pkg::WDT_STATUS_OFF, 32'h1);
    apb(1'b1, wdt_pkg::WDT_STATUS_OFF, 32'h1);
    rdchk(wdt_pkg::WDT_STATUS_OFF, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    apb(1'b1, wdt_pkg::WDT_MASK_OFF, 32'h0);
    tick(T);
    repeat (12) @(posedge clk);
    cmp(seen, 2);
    cmp({31'h0, irq}, 32'h0);
    rdchk(16'hff50, 32'h0);
    cmp({31'h0, err}, 32'h1);
    test_done();
  end
endmodule : tb_wdt_top
`default_nettype wire

/* wdt_counter.sv */
`timescale 1ns/1ns
`default_nettype none
module wdt_counter #(
  parameter int                 CNT_W = wdt_pkg::WDT_CNT_W,
  parameter logic [CNT_W-1:0]   LIMIT = CNT_W'(wdt_pkg::WDT_TIMEOUT_TICKS)
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             osc_in,
  input  wire logic             run,
  input  wire logic             restart,
  output logic [CNT_W-1:0]      count_q,
  output logic                  expire_q
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1'b1);

  logic osc_prev_q;
  logic tick;

  ////////////////////////////////////////////////////////////////////////////
  // oscillator edge detect
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_in;
    end
  end

  assign tick = osc_in & ~osc_prev_q & run;

  ////////////////////////////////////////////////////////////////////////////
  // tick counter, restart wins over a tick
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= '0;
    end else if (restart) begin
      count_q <= '0;
    end else if (tick) begin
      if (count_q == LAST) begin
        count_q <= '0;
      end else begin
        count_q <= count_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      expire_q <= 1'b0;
    end else begin
      expire_q <= tick & ~restart & (count_q == LAST);
    end
  end

endmodule : wdt_counter
`default_nettype wire

/* wdt_cpu_model.sv */
`timescale 1ns/1ns
`default_nettype none
module wdt_cpu_model (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       nmi_req_q,
  input  wire logic [3:0] ack_delay,
  output logic            nmi_ack,
  output int              nmi_seen
);
  logic [3:0] wait_q;
  // accept a pending request after a delay, one pulse each
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_q   <= 4'h0;
      nmi_ack  <= 1'b0;
      nmi_seen <= 0;
    end else if (nmi_req_q && !nmi_ack && wait_q == ack_delay) begin
      wait_q   <= 4'h0;
      nmi_ack  <= 1'b1;
      nmi_seen <= nmi_seen + 1;
    end else begin
      wait_q   <= (nmi_req_q && !nmi_ack) ? wait_q + 4'h1 : 4'h0;
      nmi_ack  <= 1'b0;
    end
  end
endmodule : wdt_cpu_model
`default_nettype wire

/* wdt_pkg.sv */
package wdt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam logic [15:0] WDT_CTRL_OFF   = 16'hff40;
  localparam logic [15:0] WDT_STATUS_OFF = 16'hff44;
  localparam logic [15:0] WDT_MASK_OFF   = 16'hff48;
  localparam logic [15:0] WDT_COUNT_OFF  = 16'hff4c;

  ////////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int          WDT_RESTART_BIT  = 2;
  localparam int          WDT_EV_TIMEOUT   = 0;
  localparam int          WDT_EV_W         = 1;
  localparam logic [7:0]  WDT_CTRL_RESET   = 8'h00;
  localparam logic [7:0]  WDT_CTRL_STORE   = 8'h7b;
  localparam logic [0:0]  WDT_STATUS_RESET = 1'h0;
  localparam logic [0:0]  WDT_MASK_RESET   = 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  // timing: timeout in low-speed oscillator ticks
  localparam int          WDT_OSC_HZ        = 32768;
  localparam int          WDT_TIMEOUT_MS    = 3500;
  localparam int          WDT_TIMEOUT_TICKS = WDT_OSC_HZ * WDT_TIMEOUT_MS / 1000;
  localparam int          WDT_CNT_W         = 17;

  ////////////////////////////////////////////////////////////////////////////
  // exception routing toward the cpu
  localparam logic [23:0] WDT_NMI_VECTOR = 24'h00_0004;
  localparam logic [2:0]  WDT_NMI_LEVEL  = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // apb carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } wdt_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } wdt_apb_rsp_t;

endpackage : wdt_pkg

/* wdt_top.sv */
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - counter advances only on rising edges of the low-speed oscillator
// - no restart for about 3.5 s at 32.768 kHz raises the nmi request
// - halt does not stop the counter; only sleep freezes it
// - during sleep the counter holds and raises nothing
// - request drives the cpu non-maskable input at level 4, no mask
// - the exception vector presented with the request is 000004H
// - writing one to the restart bit clears the count, counting resumes
// - restart bit is write-only: zero does nothing, reads give zero
module wdt_top #(
  parameter int                     CNT_W         = wdt_pkg::WDT_CNT_W,
  parameter logic [CNT_W-1:0]       TIMEOUT_TICKS = CNT_W'(wdt_pkg::WDT_TIMEOUT_TICKS)
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire wdt_pkg::wdt_apb_req_t apb_req,
  output wdt_pkg::wdt_apb_rsp_t     apb_rsp_q,
  input  wire logic                 low_speed_oscillator,
  input  wire logic                 sleep_active,
  input  wire logic                 nmi_ack,
  output logic                      nmi_req_q,
  output logic [2:0]                nmi_level_q,
  output logic [23:0]               nmi_vector_q,
  output logic                      irq_q,
  output logic [7:0]                ctrl_misc_q
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [CNT_W-1:0]                 count;
  logic                             expire;
  logic                             setup;
  logic                             wr_en;
  logic                             restart;
  logic [wdt_pkg::WDT_EV_W-1:0]     status_q;
  logic [wdt_pkg::WDT_EV_W-1:0]     mask_q;
  logic [wdt_pkg::WDT_EV_W-1:0]     status_d;
  logic [31:0]                      rd_data;
  logic                             rd_hit;

  // address match on a full byte address
  function automatic logic is_reg(input logic [15:0] addr, input logic [15:0] off);
    is_reg = (addr == off);
  endfunction : is_reg

  ////////////////////////////////////////////////////////////////////////////
  // apb phase decode
  assign setup = apb_req.psel & ~apb_req.penable;
  assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite & apb_rsp_q.pready;

  assign restart = wr_en & is_reg(apb_req.paddr, wdt_pkg::WDT_CTRL_OFF)
                   & apb_req.pwdata[wdt_pkg::WDT_RESTART_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // watchdog counter
  // halt keeps counting
  wdt_counter #(
    .CNT_W    (CNT_W),
    .LIMIT    (TIMEOUT_TICKS)
  ) u_counter (
    .clk      (clk),
    .rstn     (rstn),
    .osc_in   (low_speed_oscillator),
    .run      (~sleep_active),
    .restart  (restart),
    .count_q  (count),
    .expire_q (expire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // nmi request toward the cpu
  // hold until accepted
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nmi_req_q <= 1'b0;
    end else if (expire) begin
      nmi_req_q <= 1'b1;
    end else if (nmi_ack) begin
      nmi_req_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nmi_level_q  <= wdt_pkg::WDT_NMI_LEVEL;
      nmi_vector_q <= wdt_pkg::WDT_NMI_VECTOR;
    end else begin
      nmi_level_q  <= wdt_pkg::WDT_NMI_LEVEL;
      nmi_vector_q <= wdt_pkg::WDT_NMI_VECTOR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared control register, bits 0, 1 and 3 to 6 are plain storage, bit 7 reads zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_misc_q <= wdt_pkg::WDT_CTRL_RESET;
    end else if (wr_en && is_reg(apb_req.paddr, wdt_pkg::WDT_CTRL_OFF)) begin
      ctrl_misc_q <= apb_req.pwdata[7:0] & wdt_pkg::WDT_CTRL_STORE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky event status, set wins over write-one-to-clear
  always_comb begin
    status_d = status_q;
    if (wr_en && is_reg(apb_req.paddr, wdt_pkg::WDT_STATUS_OFF)) begin
      status_d = status_q & ~apb_req.pwdata[wdt_pkg::WDT_EV_W-1:0];
    end
    if (expire) begin
      status_d[wdt_pkg::WDT_EV_TIMEOUT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_q <= wdt_pkg::WDT_STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // interrupt mask
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_q <= wdt_pkg::WDT_MASK_RESET;
    end else if (wr_en && is_reg(apb_req.paddr, wdt_pkg::WDT_MASK_OFF)) begin
      mask_q <= apb_req.pwdata[wdt_pkg::WDT_EV_W-1:0];
    end
  end

  // level interrupt from masked status
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_d & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (is_reg(apb_req.paddr, wdt_pkg::WDT_CTRL_OFF)) begin
      rd_data[7:0] = ctrl_misc_q;
    end else if (is_reg(apb_req.paddr, wdt_pkg::WDT_STATUS_OFF)) begin
      rd_data[wdt_pkg::WDT_EV_W-1:0] = status_q;
    end else if (is_reg(apb_req.paddr, wdt_pkg::WDT_MASK_OFF)) begin
      rd_data[wdt_pkg::WDT_EV_W-1:0] = mask_q;
    end else if (is_reg(apb_req.paddr, wdt_pkg::WDT_COUNT_OFF)) begin
      rd_data[CNT_W-1:0] = count;
    end else begin
      rd_hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb response: ready in the first access cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      apb_rsp_q <= '0;
    end else if (setup) begin
      apb_rsp_q.pready  <= 1'b1;
      apb_rsp_q.pslverr <= ~rd_hit;
      apb_rsp_q.prdata  <= apb_req.pwrite ? 32'h0000_0000 : rd_data;
    end else begin
      apb_rsp_q <= '0;
    end
  end

endmodule : wdt_top
`default_nettype wire

/* wdt_top_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module wdt_top_chk (
  input wire logic                  clk,
  input wire logic                  rstn,
  input wire wdt_pkg::wdt_apb_req_t apb_req,
  input wire wdt_pkg::wdt_apb_rsp_t apb_rsp_q,
  input wire logic                  low_speed_oscillator,
  input wire logic                  sleep_active,
  input wire logic                  nmi_ack,
  input wire logic                  nmi_req_q
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  // bus answer timing and read data, nmi request behaviour
  chk_ready_after_setup: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp_q.pready)
    else $error("no ready after setup");
  chk_ready_one_cycle: assert property (apb_rsp_q.pready |=> !apb_rsp_q.pready)
    else $error("ready held too long");
  chk_bad_addr_err: assert property (apb_rsp_q.pready && apb_req.paddr[15:4] != 12'hff4 |-> apb_rsp_q.pslverr)
    else $error("unmapped without error");
  chk_restart_reads_zero: assert property (apb_rsp_q.pready && !apb_req.pwrite &&
    apb_req.paddr == wdt_pkg::WDT_CTRL_OFF |-> apb_rsp_q.prdata[2] == 1'b0)
    else $error("restart bit read high");
  chk_req_held: assert property (nmi_req_q && !nmi_ack |=> nmi_req_q)
    else $error("nmi dropped early");
  chk_ack_clears: assert property (nmi_req_q && nmi_ack |=> !nmi_req_q)
    else $error("nmi not cleared");
  chk_osc_drives_nmi: assert property (!low_speed_oscillator [*6] |=> !$rose(nmi_req_q))
    else $error("nmi without tick");
  chk_sleep_no_nmi: assert property (sleep_active [*4] |=> !$rose(nmi_req_q))
    else $error("nmi during sleep");
endmodule : wdt_top_chk
bind wdt_top wdt_top_chk u_chk (.clk(clk), .rstn(rstn), .apb_req(apb_req), .apb_rsp_q(apb_rsp_q),
  .low_speed_oscillator(low_speed_oscillator), .sleep_active(sleep_active), .nmi_ack(nmi_ack),
  .nmi_req_q(nmi_req_q));
`default_nettype wire
